// ===== verilog/ectr_pkg.sv
// Package for the expander configuration tail register bank.
// Assumes a single 10 MHz clock and an I2C master on the far side.
package ectr_pkg;

  // Default slave address, answered after every reset
  localparam logic [6:0] I2C_SLAVE_ADDR = 7'h45;
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [3:0] LAST_TX_BIT    = 4'h7;

  // Register offsets
  localparam logic [7:0] OFF_PY_LO    = 8'hE2;
  localparam logic [7:0] OFF_PY_HI    = 8'hE3;
  localparam logic [7:0] OFF_PC_LO    = 8'hE4;
  localparam logic [7:0] OFF_PC_HI    = 8'hE5;
  localparam logic [7:0] OFF_EVT_CODE = 8'hE6;
  localparam logic [7:0] OFF_RSVD     = 8'hE7;
  localparam logic [7:0] OFF_DEBOUNCE = 8'hE8;
  localparam logic [7:0] OFF_WAKE0    = 8'hE9;
  localparam logic [7:0] OFF_WAKE1    = 8'hEA;
  localparam logic [7:0] OFF_WAKE2    = 8'hEB;
  localparam logic [7:0] OFF_SEL0     = 8'hEC;
  localparam logic [7:0] OFF_SEL1     = 8'hED;
  localparam logic [7:0] OFF_SEL2     = 8'hEE;
  localparam logic [7:0] OFF_SEL3     = 8'hEF;
  localparam logic [7:0] OFF_IRQ_RAW  = 8'hF0;
  localparam logic [7:0] OFF_IRQ_MIS  = 8'hF1;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'hF2;
  localparam logic [7:0] OFF_IRQ_MSK  = 8'hF3;
  localparam logic [7:0] OFF_SOFT_RST = 8'h88;
  localparam logic [7:0] OFF_BALL_SEL = 8'h89;

  // Field positions
  localparam int IRQ_EVT_BIT  = 0;
  localparam int IRQ_REL_BIT  = 1;
  localparam int CLR_EVT_BIT  = 0;
  localparam int SOFT_RST_BIT = 0;

  // Reset values and encodings
  localparam logic [5:0]  RST_EVT_CODE = 6'h3F;
  localparam logic [25:0] PULL_ALL     = 26'h3FFFFFF;
  localparam logic [1:0]  BALL_DIR_KEY = 2'h0;
  localparam logic [1:0]  BALL_EXT_CLK = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ADDR  = 3'b001,
    S_REG   = 3'b010,
    S_WDATA = 3'b011,
    S_ACK   = 3'b100,
    S_RDATA = 3'b101,
    S_RACK  = 3'b110
  } ectr_i2c_state_t;

  typedef struct packed {
    logic [1:0] ball;
    logic [1:0] irq_mask;
    logic [1:0] sel3;
    logic [7:0] sel2;
    logic [7:0] sel1;
    logic [7:0] sel0;
    logic [7:0] wake2;
    logic [7:0] wake1;
    logic [7:0] wake0;
    logic [5:0] debounce;
  } ectr_cfg_t;

  localparam ectr_cfg_t CFG_RST = '{ball: 2'h0, irq_mask: 2'h0, sel3: 2'h3,
                                    sel2: 8'hFF, sel1: 8'hFF, sel0: 8'hFF,
                                    wake2: 8'h00, wake1: 8'h00, wake0: 8'h00,
                                    debounce: 6'h06};

  typedef struct packed {
    logic       press;
    logic       release_evt;
    logic       held;
    logic [4:0] code;
  } ectr_key_evt_t;

endpackage

// ===== verilog/ectr_pair16.sv
// Byte-paired 16-bit register: both halves staged, committed together.
// Assumes the writer presents one byte per write strobe.
module ectr_pair16
  import ectr_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Byte write
  input  wire logic        wr_en,
  input  wire logic        wr_hi,
  input  wire logic [7:0]  wr_data,
  // Committed value
  output logic      [15:0] value
);

  logic [7:0]  lo;
  logic [7:0]  hi;
  logic        got_lo;
  logic        got_hi;
  logic [7:0]  next_lo;
  logic [7:0]  next_hi;
  logic        next_got_lo;
  logic        next_got_hi;
  logic [15:0] next_value;

  always_comb
  begin
    next_lo     = lo;
    next_hi     = hi;
    next_got_lo = got_lo;
    next_got_hi = got_hi;
    next_value  = value;
    if (wr_en)
    begin
      if (wr_hi)
      begin
        next_hi     = wr_data;
        next_got_hi = 1'b1;
      end
      else
      begin
        next_lo     = wr_data;
        next_got_lo = 1'b1;
      end
      // Either order works; a lone byte never reaches the value
      if (next_got_lo && next_got_hi)
      begin
        next_value  = {next_hi, next_lo};
        next_got_lo = 1'b0;
        next_got_hi = 1'b0;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      lo     <= 8'h00;
      hi     <= 8'h00;
      got_lo <= 1'b0;
      got_hi <= 1'b0;
      value  <= 16'h0000;
    end
    else
    begin
      lo     <= next_lo;
      hi     <= next_hi;
      got_lo <= next_got_lo;
      got_hi <= next_got_hi;
      value  <= next_value;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_pair_hold: assert property (wr_en && !wr_hi && !got_hi |=> $stable(value))
    else $error("paired value changed on a single byte");
  a_pair_commit: assert property (wr_en && wr_hi && got_lo |=>
    value == {$past(wr_data), $past(lo)})
    else $error("paired value not committed after both bytes");
  c_pair_commit: cover property (wr_en && wr_hi && got_lo);

endmodule

// ===== verilog/ectr_regs.sv
// Configuration tail register bank of the I/O expander, I2C slave access.
// Assumes SCL and SDA arrive synchronous to clock; SDA wire resolved outside.
// Function
// - Paired registers commit their 16-bit value only after both bytes are written.
// - Global reset from I2C command, power-on reset or the active-low reset pin.
// - After reset the slave answers the seven-bit address 1000101.
// - Pull-ups on key, PWM, extension and direct-key pins are enabled.
// - Ball select 0x2 takes the system clock from direct key pin 24.
// - Ball select 0x0 makes pin 24 a key and uses the RC oscillator.
module ectr_regs
  import ectr_pkg::*;
(
  // Clock and resets
  input  wire logic          clock,
  input  wire logic          srst,
  input  wire logic          reset_pin_low,
  // I2C slave pins
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  output logic               sda_out,
  output logic               sda_oe_n,
  // Dedicated-key scanner events
  input  wire ectr_key_evt_t key_evt,
  // Configuration and status towards the rest of the chip
  output ectr_cfg_t          cfg,
  output logic        [15:0] port_y_drain,
  output logic        [15:0] port_c_drain,
  output logic        [25:0] pad_pull_up,
  output logic               ext_clock_sel,
  output logic               pin24_key_en,
  output logic        [1:0]  key_irq_masked
);

  ////////////////////////////////////////////////////////////////////////////
  logic            grst;
  logic            scl_q;
  logic            sda_q;
  logic            scl_rise;
  logic            scl_fall;
  logic            start;
  logic            stop;
  ectr_i2c_state_t state;
  ectr_i2c_state_t next_state;
  ectr_i2c_state_t ack_to;
  ectr_i2c_state_t next_ack_to;
  logic [3:0]      cnt;
  logic [3:0]      next_cnt;
  logic [7:0]      sh;
  logic [7:0]      next_sh;
  logic [7:0]      tx;
  logic [7:0]      next_tx;
  logic [7:0]      ptr;
  logic [7:0]      next_ptr;
  logic            nacked;
  logic            next_nacked;
  logic            next_drive;
  logic            wr_stb;
  ectr_cfg_t       next_cfg;
  logic [5:0]      ev_code;
  logic [5:0]      next_ev_code;
  logic [1:0]      irq_raw;
  logic [1:0]      next_irq_raw;
  logic            soft_pend;
  logic            next_soft_pend;
  logic            soft_rst;
  logic            next_soft_rst;

  // Any of the three sources resets the whole bank and the slave
  assign grst     = srst || !reset_pin_low || soft_rst;
  assign scl_rise = scl_in && !scl_q;
  assign scl_fall = !scl_in && scl_q;
  assign start    = scl_in && scl_q && sda_q && !sda_in;
  assign stop     = scl_in && scl_q && !sda_q && sda_in;
  assign wr_stb   = (state == S_WDATA) && scl_fall && (cnt == BYTE_BITS);

  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    case (a)
      OFF_PY_LO:    rd_byte = port_y_drain[7:0];
      OFF_PY_HI:    rd_byte = port_y_drain[15:8];
      OFF_PC_LO:    rd_byte = port_c_drain[7:0];
      OFF_PC_HI:    rd_byte = port_c_drain[15:8];
      OFF_EVT_CODE: rd_byte = {2'h0, ev_code};
      OFF_DEBOUNCE: rd_byte = {2'h0, cfg.debounce};
      OFF_WAKE0:    rd_byte = cfg.wake0;
      OFF_WAKE1:    rd_byte = cfg.wake1;
      OFF_WAKE2:    rd_byte = cfg.wake2;
      OFF_SEL0:     rd_byte = cfg.sel0;
      OFF_SEL1:     rd_byte = cfg.sel1;
      OFF_SEL2:     rd_byte = cfg.sel2;
      OFF_SEL3:     rd_byte = {6'h00, cfg.sel3};
      OFF_IRQ_RAW:  rd_byte = {6'h00, irq_raw};
      OFF_IRQ_MIS:  rd_byte = {6'h00, key_irq_masked};
      OFF_IRQ_MSK:  rd_byte = {6'h00, cfg.irq_mask};
      OFF_BALL_SEL: rd_byte = {6'h00, cfg.ball};
      default:      rd_byte = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // I2C slave: sample on SCL rise, change SDA after SCL fall
  always_comb
  begin
    next_state  = state;
    next_cnt    = cnt;
    next_sh     = sh;
    next_tx     = tx;
    next_ptr    = ptr;
    next_ack_to = ack_to;
    next_nacked = nacked;
    if (scl_rise)
    begin
      if (state == S_ADDR || state == S_REG || state == S_WDATA)
      begin
        next_sh  = {sh[6:0], sda_in};
        next_cnt = cnt + 4'h1;
      end
      if (state == S_RACK)
        next_nacked = sda_in;
    end
    if (scl_fall)
    begin
      case (state)
        S_ADDR:
          if (cnt == BYTE_BITS)
          begin
            if (sh[7:1] == I2C_SLAVE_ADDR)
            begin
              next_state  = S_ACK;
              next_cnt    = 4'h0;
              next_ack_to = sh[0] ? S_RDATA : S_REG;
              next_tx     = rd_byte(ptr);
            end
            else
              next_state = S_IDLE;
          end
        S_REG:
          if (cnt == BYTE_BITS)
          begin
            next_ptr    = sh;
            next_state  = S_ACK;
            next_cnt    = 4'h0;
            next_ack_to = S_WDATA;
          end
        S_WDATA:
          if (cnt == BYTE_BITS)
          begin
            next_ptr    = 8'(ptr + 8'h01);
            next_state  = S_ACK;
            next_cnt    = 4'h0;
            next_ack_to = S_WDATA;
          end
        S_ACK:
          next_state = ack_to;
        S_RDATA:
          if (cnt == LAST_TX_BIT)
          begin
            next_state = S_RACK;
            next_cnt   = 4'h0;
          end
          else
          begin
            next_tx  = {tx[6:0], 1'b0};
            next_cnt = cnt + 4'h1;
          end
        S_RACK:
          if (nacked)
            next_state = S_IDLE;
          else
          begin
            next_ptr   = 8'(ptr + 8'h01);
            next_tx    = rd_byte(8'(ptr + 8'h01));
            next_state = S_RDATA;
          end
        default:
          next_state = S_IDLE;
      endcase
    end
    if (start)
    begin
      next_state = S_ADDR;
      next_cnt   = 4'h0;
    end
    else if (stop)
      next_state = S_IDLE;
    // Open drain: only ever pull low, a one is a released line
    next_drive = (next_state == S_ACK) || (next_state == S_RDATA && !next_tx[7]);
  end

  always_ff @(posedge clock)
  begin
    if (grst)
    begin
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      state    <= S_IDLE;
      cnt      <= 4'h0;
      sh       <= 8'h00;
      tx       <= 8'h00;
      ptr      <= 8'h00;
      ack_to   <= S_IDLE;
      nacked   <= 1'b0;
      sda_out  <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      scl_q    <= scl_in;
      sda_q    <= sda_in;
      state    <= next_state;
      cnt      <= next_cnt;
      sh       <= next_sh;
      tx       <= next_tx;
      ptr      <= next_ptr;
      ack_to   <= next_ack_to;
      nacked   <= next_nacked;
      sda_out  <= 1'b0;
      sda_oe_n <= !next_drive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bank
  always_comb
  begin
    next_cfg       = cfg;
    next_ev_code   = ev_code;
    next_irq_raw   = irq_raw;
    next_soft_pend = soft_pend;
    next_soft_rst  = 1'b0;
    if (wr_stb)
    begin
      case (ptr)
        OFF_DEBOUNCE: next_cfg.debounce = sh[5:0];
        OFF_WAKE0:    next_cfg.wake0 = sh;
        OFF_WAKE1:    next_cfg.wake1 = sh;
        OFF_WAKE2:    next_cfg.wake2 = sh;
        OFF_SEL0:     next_cfg.sel0 = sh;
        OFF_SEL1:     next_cfg.sel1 = sh;
        OFF_SEL2:     next_cfg.sel2 = sh;
        OFF_SEL3:     next_cfg.sel3 = sh[1:0];
        OFF_IRQ_MSK:  next_cfg.irq_mask = sh[1:0];
        OFF_BALL_SEL: next_cfg.ball = sh[1:0];
        OFF_IRQ_CLR:
          if (sh[CLR_EVT_BIT])
            next_irq_raw = 2'h0;
        OFF_SOFT_RST:
          if (sh[SOFT_RST_BIT])
            next_soft_pend = 1'b1;
        // Write-prohibited slot: dropped here so a stray write stays harmless
        OFF_RSVD:     next_soft_pend = soft_pend;
        default:      next_soft_pend = soft_pend;
      endcase
    end
    // A key event in the clearing cycle wins over the clear
    if (key_evt.press || key_evt.release_evt)
    begin
      next_ev_code              = {key_evt.held, key_evt.code};
      next_irq_raw[IRQ_EVT_BIT] = 1'b1;
      if (key_evt.release_evt)
        next_irq_raw[IRQ_REL_BIT] = 1'b1;
    end
    // Defer the I2C reset to STOP so the command byte is still acknowledged
    if (soft_pend && stop)
      next_soft_rst = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (grst)
    begin
      cfg            <= CFG_RST;
      ev_code        <= RST_EVT_CODE;
      irq_raw        <= 2'h0;
      soft_pend      <= 1'b0;
      soft_rst       <= 1'b0;
      pad_pull_up    <= PULL_ALL;
      ext_clock_sel  <= 1'b0;
      pin24_key_en   <= 1'b1;
      key_irq_masked <= 2'h0;
    end
    else
    begin
      cfg            <= next_cfg;
      ev_code        <= next_ev_code;
      irq_raw        <= next_irq_raw;
      soft_pend      <= next_soft_pend;
      soft_rst       <= next_soft_rst;
      pad_pull_up    <= PULL_ALL;
      ext_clock_sel  <= (next_cfg.ball == BALL_EXT_CLK);
      pin24_key_en   <= (next_cfg.ball == BALL_DIR_KEY);
      key_irq_masked <= next_irq_raw & next_cfg.irq_mask;
    end
  end

  ectr_pair16 u_pair_y (
    .clock   (clock),
    .srst    (grst),
    .wr_en   (wr_stb && (ptr == OFF_PY_LO || ptr == OFF_PY_HI)),
    .wr_hi   (ptr == OFF_PY_HI),
    .wr_data (sh),
    .value   (port_y_drain)
  );

  ectr_pair16 u_pair_c (
    .clock   (clock),
    .srst    (grst),
    .wr_en   (wr_stb && (ptr == OFF_PC_LO || ptr == OFF_PC_HI)),
    .wr_hi   (ptr == OFF_PC_HI),
    .wr_data (sh),
    .value   (port_c_drain)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_pin_reset: assert property (!reset_pin_low |=> state == S_IDLE && cfg == CFG_RST)
    else $error("reset pin did not reset the bank");
  a_soft_reset: assert property (soft_rst |=> ev_code == RST_EVT_CODE && !soft_pend)
    else $error("I2C reset command did not reset the bank");
  a_addr_ack: assert property (state == S_ADDR && scl_fall && cnt == BYTE_BITS &&
    sh[7:1] == I2C_SLAVE_ADDR && !start && !stop |=> state == S_ACK ##0 !sda_oe_n)
    else $error("default address not acknowledged");
  a_pull_ups: assert property (##1 pad_pull_up == PULL_ALL)
    else $error("pad pull-ups not enabled");
  a_ext_clock: assert property (cfg.ball == BALL_EXT_CLK |-> ext_clock_sel && !pin24_key_en)
    else $error("external clock not selected");
  a_rc_clock: assert property (cfg.ball == BALL_DIR_KEY |-> pin24_key_en && !ext_clock_sel)
    else $error("pin 24 not a key under RC clock");
  a_irq_masked: assert property (key_irq_masked == (irq_raw & cfg.irq_mask))
    else $error("masked status differs from gated raw status");
  a_irq_clear: assert property (wr_stb && ptr == OFF_IRQ_CLR && sh[CLR_EVT_BIT] &&
    !key_evt.press && !key_evt.release_evt && !grst |=> irq_raw == 2'h0)
    else $error("event clear did not drop raw status");
  a_set_wins: assert property (key_evt.press && !grst |=> irq_raw[IRQ_EVT_BIT])
    else $error("key event lost");

  c_read_byte: cover property (state == S_RACK && scl_fall && !nacked);
  c_write_byte: cover property (wr_stb);
  c_soft_reset: cover property (soft_rst);

endmodule

// ===== test/ectr_i2c_host.sv
// Behavioural I2C master standing in for the host processor.
// Assumes a pull-up on SDA; sda_line is the resolved wire level.
module ectr_i2c_host
  import ectr_pkg::*;
(
  // Clock
  input  wire logic clock,
  // Bus
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_m
);
  timeunit 1ns;
  timeprecision 100ps;

  logic got;

  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Four clocks a phase keeps SCL well above the two-clock minimum
  task automatic ph();
    repeat (4) @(posedge clock);
    #10;
  endtask

  // SDA only moves while SCL is low, so no false START or STOP
  task automatic bit_io(input logic b);
    sda_m = b;
    ph();
    scl = 1'b1;
    ph();
    got = sda_line;
    scl = 1'b0;
    ph();
  endtask

  task automatic start();
    sda_m = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_m = 1'b0;
    ph();
    scl = 1'b0;
    ph();
  endtask

  task automatic stop();
    sda_m = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda_m = 1'b1;
    ph();
  endtask

  task automatic send(input logic [7:0] d, inout logic ok);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i]);
    bit_io(1'b1);
    ok &= !got;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic probe(input logic [6:0] adr, output logic ok);
    ok = 1'b1;
    start();
    send({adr, 1'b0}, ok);
    stop();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    ok = 1'b1;
    // Write-prohibited slot is never touched
    if (a == OFF_RSVD)
      return;
    start();
    send({I2C_SLAVE_ADDR, 1'b0}, ok);
    send(a, ok);
    send(d, ok);
    stop();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    send({I2C_SLAVE_ADDR, 1'b0}, ok);
    send(a, ok);
    start();
    send({I2C_SLAVE_ADDR, 1'b1}, ok);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1);
      d[i] = got;
    end
    bit_io(1'b1);
    stop();
  endtask

  task automatic wr2(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1,
                     output logic ok);
    ok = 1'b1;
    // A burst that would cross the write-prohibited slot is never issued
    if (a == OFF_RSVD || 8'(a + 8'h01) == OFF_RSVD)
      return;
    start();
    send({I2C_SLAVE_ADDR, 1'b0}, ok);
    send(a, ok);
    send(d0, ok);
    send(d1, ok);
    stop();
  endtask

  // Two-byte read: master acknowledges the first byte, refuses the second
  task automatic rd2(input logic [7:0] a, output logic [15:0] d, output logic ok);
    ok = 1'b1;
    start();
    send({I2C_SLAVE_ADDR, 1'b0}, ok);
    send(a, ok);
    start();
    send({I2C_SLAVE_ADDR, 1'b1}, ok);
    for (int i = 15; i >= 0; i--)
    begin
      bit_io(1'b1);
      d[i] = got;
      if (i == 8)
        bit_io(1'b0);
    end
    bit_io(1'b1);
    stop();
  endtask
endmodule

// ===== test/test_ectr_regs.sv
// Self-checking bench for the configuration tail register bank.
// Assumes the host model owns SCL and its SDA pull; SDA has a pull-up.
module test_ectr_regs
  import ectr_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  logic          clock;
  logic          srst;
  logic          reset_pin_low;
  logic          scl;
  logic          sda_m;
  logic          sda_line;
  logic          sda_out;
  logic          sda_oe_n;
  ectr_key_evt_t key_evt;
  ectr_cfg_t     cfg;
  logic [15:0]   port_y_drain;
  logic [15:0]   port_c_drain;
  logic [25:0]   pad_pull_up;
  logic          ext_clock_sel;
  logic          pin24_key_en;
  logic [1:0]    key_irq_masked;
  logic [7:0]    rdat;
  logic [15:0]   rdat16;
  logic          ok;
  int            err_count;
  int            n_tests;

  // Reset values from 0xE2 up to 0xF3; 0xF2 is write-only and skipped
  localparam logic [7:0] RST_TAB [18] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h00,
    8'h06, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
  // Offset, written byte, read-back byte (narrow fields drop upper bits)
  localparam logic [23:0] RW_TAB [4] = '{24'hE8D515, 24'hECA5A5, 24'hEFFE02, 24'hEB3C3C};

  assign sda_line = sda_m & (sda_oe_n | sda_out);

  initial
    clock = 1'b0;
  always #50 clock = ~clock;

  ectr_regs i_ectr_regs (.clock, .srst, .reset_pin_low, .scl_in(scl), .sda_in(sda_line),
    .sda_out, .sda_oe_n, .key_evt, .cfg, .port_y_drain, .port_c_drain, .pad_pull_up,
    .ext_clock_sel, .pin24_key_en, .key_irq_masked);
  ectr_i2c_host i_ectr_i2c_host (.clock, .sda_line, .scl, .sda_m);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_ectr_i2c_host.wr(a, d, ok);
    chk(ok, 1'b1, "write ack");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    i_ectr_i2c_host.rd(a, rdat, ok);
    chk(ok, 1'b1, "read ack");
    chk(rdat, exp, "read data");
  endtask

  task automatic key(input logic rel, input logic [5:0] hc);
    key_evt = '{press: !rel, release_evt: rel, held: hc[5], code: hc[4:0]};
    @(posedge clock);
    #10;
    key_evt = '0;
    @(posedge clock);
    #10;
  endtask

  // Source 0 power-on, 1 reset pin, 2 I2C command (lands after STOP)
  task automatic pulse_reset(input int src);
    case (src)
      0: srst = 1'b1;
      1: reset_pin_low = 1'b0;
      default: wr(OFF_SOFT_RST, 8'h01);
    endcase
    @(posedge clock);
    #10;
    srst = 1'b0;
    reset_pin_low = 1'b1;
    repeat (2) @(posedge clock);
    #10;
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Longest path is some 54 transfers of about 420 clocks
  initial
  begin
    repeat (60000) @(posedge clock);
    err_count++;
    finish_test();
  end

  initial
  begin
    srst = 1'b1;
    reset_pin_low = 1'b1;
    key_evt = '0;
    err_count = 0;
    n_tests = 0;
    repeat (8) @(posedge clock);
    #10;
    srst = 1'b0;
    chk(pad_pull_up, 26'h3FFFFFF, "pull-ups");
    chk({ext_clock_sel, pin24_key_en}, 2'h1, "clock after reset");
    for (int i = 0; i < 18; i++)
      if (8'(8'hE2 + i) != OFF_IRQ_CLR)
        rd_chk(8'(8'hE2 + i), RST_TAB[i]);
    i_ectr_i2c_host.probe(I2C_SLAVE_ADDR ^ 7'h01, ok);
    chk(ok, 1'b0, "foreign address");
    foreach (RW_TAB[i])
    begin
      wr(RW_TAB[i][23:16], RW_TAB[i][15:8]);
      rd_chk(RW_TAB[i][23:16], RW_TAB[i][7:0]);
    end
    chk(cfg.debounce, 6'h15, "debounce out");
    // A lone half must never reach the committed value
    wr(OFF_PY_LO, 8'h5A);
    chk(port_y_drain, 16'h0000, "lone low byte");
    rd_chk(OFF_PY_LO, 8'h00);
    wr(OFF_PY_HI, 8'hC3);
    chk(port_y_drain, 16'hC35A, "pair commit");
    wr(OFF_PY_LO, 8'h11);
    chk(port_y_drain, 16'hC35A, "second lone byte");
    wr(OFF_PC_HI, 8'h81);
    chk(port_c_drain, 16'h0000, "lone high byte");
    wr(OFF_PC_LO, 8'h7E);
    chk(port_c_drain, 16'h817E, "pair commit");
    rd_chk(OFF_PC_HI, 8'h81);
    i_ectr_i2c_host.wr2(OFF_PC_LO, 8'h3C, 8'hA5, ok);
    chk(ok, 1'b1, "burst write ack");
    chk(port_c_drain, 16'hA53C, "burst pair commit");
    i_ectr_i2c_host.rd2(OFF_PC_LO, rdat16, ok);
    chk(ok, 1'b1, "burst read ack");
    chk(rdat16, 16'h3CA5, "burst read");
    wr(OFF_BALL_SEL, {6'h00, BALL_EXT_CLK});
    chk({ext_clock_sel, pin24_key_en}, 2'h2, "external clock");
    wr(OFF_BALL_SEL, {6'h00, BALL_DIR_KEY});
    chk({ext_clock_sel, pin24_key_en}, 2'h1, "rc clock");
    key(1'b0, 6'h25);
    rd_chk(OFF_EVT_CODE, 8'h25);
    rd_chk(OFF_IRQ_RAW, 8'h01);
    chk(key_irq_masked, 2'b00, "masked off");
    wr(OFF_IRQ_MSK, 8'h03);
    chk(key_irq_masked, 2'b01, "masked on");
    key(1'b1, 6'h0A);
    rd_chk(OFF_IRQ_MIS, 8'h03);
    wr(OFF_IRQ_MSK, 8'h02);
    chk(key_irq_masked, 2'b10, "release only");
    wr(OFF_IRQ_CLR, 8'h01);
    rd_chk(OFF_IRQ_RAW, 8'h00);
    chk(key_irq_masked, 2'b00, "cleared");
    for (int s = 0; s < 3; s++)
    begin
      wr(OFF_DEBOUNCE, 8'h2B);
      wr(OFF_IRQ_MSK, 8'h03);
      pulse_reset(s);
      chk(cfg.debounce, 6'h06, "debounce reset");
      rd_chk(OFF_IRQ_MSK, 8'h00);
    end
    finish_test();
  end
endmodule
